// file: core/gpp_pkg.sv
// Purpose: constants for the general purpose port pin block
// Assumes: 16-bit register data, byte offsets as printed
// Notes:   register map, field positions and reset values live here
package gpp_pkg;
	localparam int          NPINS          = 7;
	localparam int          DW             = 16;
	localparam int          AW             = 8;
	localparam logic [7:0]  ADDR_CTRL      = 8'h5A;
	localparam logic [7:0]  ADDR_LEVEL     = 8'h5C;
	localparam logic [7:0]  ADDR_DRIVE     = 8'h5E;
	localparam int          DIR_LSB        = 0;
	localparam int          IEN_LSB        = 8;
	localparam int          DRV_BIT        = 0;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	localparam logic [15:0] LEVEL_RESET    = 16'h0000;
	localparam logic [15:0] ZERO16         = 16'h0000;
	localparam logic [6:0]  PINS_RESET     = 7'h00;
	localparam logic        DRV_RESET      = 1'b0;
	localparam logic        BUS_8BIT       = 1'b1;
endpackage

// file: core/gpp_pin_if.sv
`timescale 1ns/100ps
// Purpose: per-pin controls between the register file and the pad logic
// Assumes: single clock
// Notes:   carries direction, input enable, output level, sampled level
interface gpp_pin_if;
	logic [6:0] pin_direction;
	logic [6:0] pin_input_enable;
	logic [6:0] out_level;
	logic [6:0] in_level;
	logic       port_mode;
	modport regs (output pin_direction, output pin_input_enable, output out_level,
		output port_mode, input in_level);
	modport pads (input pin_direction, input pin_input_enable, input out_level,
		input port_mode, output in_level);
endinterface

// file: core/gpp_pads.sv
`timescale 1ns/100ps
// Purpose: pad control of the seven shared port pins
// Assumes: pin inputs synchronous to clk
// Notes:   outputs registered so the top gets flop-driven pins
module gpp_pads (
	input  wire logic       clk,
	input  wire logic       rst_n,
	gpp_pin_if.pads         pif,
	input  wire logic [6:0] pins_i,
	output logic      [6:0] pins_o,
	output logic      [6:0] pins_oe
);
	logic [6:0] o_d, o_q, oe_d, oe_q, in_d, in_q;

	// ****************
	// per pin control
	// ****************
	for (genvar i = 0; i < gpp_pkg::NPINS; i++) begin : g_pin
		always_comb begin
			// direction wins over input enable; disabled input reads zero
			oe_d[i] = pif.port_mode & pif.pin_direction[i];
			o_d[i]  = pif.port_mode & pif.pin_direction[i] & pif.out_level[i];
			in_d[i] = pif.port_mode & ~pif.pin_direction[i]
				& pif.pin_input_enable[i] & pins_i[i];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			o_q  <= gpp_pkg::PINS_RESET;
			oe_q <= gpp_pkg::PINS_RESET;
			in_q <= gpp_pkg::PINS_RESET;
		end else begin
			o_q  <= o_d;
			oe_q <= oe_d;
			in_q <= in_d;
		end
	end

	assign pins_o      = o_q;
	assign pins_oe     = oe_q;
	assign pif.in_level = in_q;

	// ****************
	// checks
	// ****************
	property p_no_drive_in;
		@(posedge clk) disable iff (!rst_n)
		!pif.pin_direction[0] |=> !pins_oe[0];
	endproperty
	a_no_drive_in: assert property (p_no_drive_in) else $error("input pin driven");
	property p_disabled_zero;
		@(posedge clk) disable iff (!rst_n)
		(!pif.pin_direction[1] && !pif.pin_input_enable[1]) |=> !in_q[1];
	endproperty
	a_disabled_zero: assert property (p_disabled_zero) else $error("disabled pin sampled");
	property p_sample;
		@(posedge clk) disable iff (!rst_n)
		(pif.port_mode && !pif.pin_direction[2] && pif.pin_input_enable[2])
			|=> in_q[2] == $past(pins_i[2]);
	endproperty
	a_sample: assert property (p_sample) else $error("input not sampled");
	property p_out;
		@(posedge clk) disable iff (!rst_n)
		(pif.port_mode && pif.pin_direction[3]) |=> (pins_oe[3] && pins_o[3] == $past(pif.out_level[3]));
	endproperty
	a_out: assert property (p_out) else $error("output not driven");
	property p_mode16;
		@(posedge clk) disable iff (!rst_n)
		!pif.port_mode |=> pins_oe == gpp_pkg::PINS_RESET;
	endproperty
	a_mode16: assert property (p_mode16) else $error("pins driven in 16-bit mode");
	c_out: cover property (@(posedge clk) disable iff (!rst_n) pins_oe[0] && pins_o[0]);
	c_in: cover property (@(posedge clk) disable iff (!rst_n) in_q[0]);
endmodule // gpp_pads

// file: core/gpp_regs.sv
`timescale 1ns/100ps
// Purpose: register file of the port block
// Assumes: one-cycle strobes, read data in the following cycle
// Notes:   unmapped reads answer zero
module gpp_regs (
	input  wire logic        clk,
	input  wire logic        rst_n,
	gpp_pin_if.regs          pif,
	input  wire logic        bus_8bit,
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	output logic             drive_strength_select
);
	logic [15:0] ctrl_q, ctrl_d, lvl_q, lvl_d, rd_q, rd_d;
	logic        drv_q, drv_d, mode_q, mode_d;

	// ****************
	// next state
	// ****************
	always_comb begin
		ctrl_d = ctrl_q;
		lvl_d  = lvl_q;
		drv_d  = drv_q;
		mode_d = (bus_8bit == gpp_pkg::BUS_8BIT);
		rd_d   = gpp_pkg::ZERO16;
		if (wr && addr == gpp_pkg::ADDR_CTRL && mode_q) begin
			ctrl_d = gpp_pkg::ZERO16;
			ctrl_d[gpp_pkg::IEN_LSB +: 7] = wdata[gpp_pkg::IEN_LSB +: 7];
			ctrl_d[gpp_pkg::DIR_LSB +: 7] = wdata[gpp_pkg::DIR_LSB +: 7];
		end
		// control and level writes in 16-bit mode are dropped; reserved bits never stored
		if (wr && addr == gpp_pkg::ADDR_LEVEL && mode_q)
			lvl_d = {9'h000, wdata[6:0]};
		if (wr && addr == gpp_pkg::ADDR_DRIVE)
			drv_d = wdata[gpp_pkg::DRV_BIT];
		if (rd) begin
			unique case (addr)
				gpp_pkg::ADDR_CTRL:
					rd_d = mode_q ? ctrl_q : gpp_pkg::ZERO16;
				gpp_pkg::ADDR_LEVEL:
					// outputs show the written level, inputs the sampled one
					rd_d = mode_q ? {9'h000, (ctrl_q[6:0] & lvl_q[6:0])
						| (~ctrl_q[6:0] & pif.in_level)} : gpp_pkg::ZERO16;
				gpp_pkg::ADDR_DRIVE:
					rd_d = {15'h0000, drv_q};
				default:
					rd_d = gpp_pkg::ZERO16;
			endcase
		end
	end

	// only the hardware reset pin clears these
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= gpp_pkg::CTRL_RESET;
			lvl_q  <= gpp_pkg::LEVEL_RESET;
			drv_q  <= gpp_pkg::DRV_RESET;
			mode_q <= 1'b0;
			rd_q   <= gpp_pkg::ZERO16;
		end else begin
			ctrl_q <= ctrl_d;
			lvl_q  <= lvl_d;
			drv_q  <= drv_d;
			mode_q <= mode_d;
			rd_q   <= rd_d;
		end
	end

	assign pif.pin_direction    = ctrl_q[gpp_pkg::DIR_LSB +: 7];
	assign pif.pin_input_enable = ctrl_q[gpp_pkg::IEN_LSB +: 7];
	assign pif.out_level        = lvl_q[6:0];
	assign pif.port_mode        = mode_q;
	assign rdata                = rd_q;
	assign drive_strength_select = drv_q;

	// ****************
	// checks
	// ****************
	property p_rsvd;
		@(posedge clk) disable iff (!rst_n)
		$past(rd) && $past(addr) == gpp_pkg::ADDR_LEVEL |-> rdata[15:7] == 9'h000;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
	property p_16_read;
		@(posedge clk) disable iff (!rst_n)
		(rd && addr == gpp_pkg::ADDR_LEVEL && !mode_q) |=> rdata == gpp_pkg::ZERO16;
	endproperty
	a_16_read: assert property (p_16_read) else $error("16-bit read not zero");
	property p_16_write;
		@(posedge clk) disable iff (!rst_n)
		(wr && addr == gpp_pkg::ADDR_LEVEL && !mode_q) |=> $stable(lvl_q);
	endproperty
	a_16_write: assert property (p_16_write) else $error("16-bit write stored");
	property p_drv;
		@(posedge clk) disable iff (!rst_n)
		(wr && addr == gpp_pkg::ADDR_DRIVE) |=> drv_q == $past(wdata[0]);
	endproperty
	a_drv: assert property (p_drv) else $error("drive select not stored");
	property p_ctrl;
		@(posedge clk) disable iff (!rst_n)
		(wr && addr == gpp_pkg::ADDR_CTRL && mode_q) |=> ctrl_q == ($past(wdata) & 16'h7F7F);
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control not stored");
	c_drv: cover property (@(posedge clk) disable iff (!rst_n) wr && addr == gpp_pkg::ADDR_DRIVE);
	c_lvl: cover property (@(posedge clk) disable iff (!rst_n) rd && addr == gpp_pkg::ADDR_LEVEL && mode_q);
endmodule // gpp_regs

// file: core/gpp_top.sv
`timescale 1ns/100ps
// Purpose: seven shared general purpose port pins with drive strength select
// Assumes: 40 MHz clk, pins synchronous, plain register port
// Notes:   reset released through two flops
module gpp_top (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        bus_width_select_pin,
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	output logic             drive_strength_select,
	input  wire logic [6:0]  shared_port_pins_i,
	output logic      [6:0]  shared_port_pins_o,
	output logic      [6:0]  shared_port_pins_oe
);
	logic [1:0] rst_sync_q;
	logic       rst_n;

	// ****************
	// reset release
	// ****************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	gpp_pin_if pif ();

	gpp_regs u_regs (
		.clk                   (clk),
		.rst_n                 (rst_n),
		.pif                   (pif.regs),
		.bus_8bit              (bus_width_select_pin),
		.addr                  (addr),
		.wdata                 (wdata),
		.wr                    (wr),
		.rd                    (rd),
		.rdata                 (rdata),
		.drive_strength_select (drive_strength_select)
	);

	gpp_pads u_pads (
		.clk     (clk),
		.rst_n   (rst_n),
		.pif     (pif.pads),
		.pins_i  (shared_port_pins_i),
		.pins_o  (shared_port_pins_o),
		.pins_oe (shared_port_pins_oe)
	);
endmodule // gpp_top

// file: sim/gpp_ext_dev.sv
// Purpose: external devices wired to the seven shared port pins
// Assumes: bench sets which pins are driven from outside and to what level
// Notes:   undriven pins float, shown as a level that flips every cycle
`timescale 1ns/100ps
module gpp_ext_dev (
	input  wire logic       clk,
	input  wire logic [6:0] pins_o,
	input  wire logic [6:0] pins_oe,
	input  wire logic [6:0] ext_val,
	input  wire logic [6:0] ext_en,
	output logic      [6:0] pins_i
);
	logic [6:0] last_q = 7'h00;

	// a floating pin must not settle to a value the simulator picked by chance
	always_ff @(posedge clk) begin
		last_q <= pins_i;
	end

	always_comb begin
		for (int i = 0; i < 7; i++) begin
			pins_i[i] = pins_oe[i] ? pins_o[i] : (ext_en[i] ? ext_val[i] : ~last_q[i]);
		end
	end
endmodule // gpp_ext_dev

// file: sim/gpp_top_bench.sv
// Purpose: self-checking bench of the shared port pin block
// Assumes: 40 MHz clock, one-cycle strobes, read data the cycle after rd
// Notes:   each scenario is its own task
`timescale 1ns/100ps
module gpp_top_bench;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        bw = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] rdata;
	logic        drv;
	logic [6:0]  p_i, p_o, p_oe;
	logic [6:0]  ext_val = 7'h00;
	logic [6:0]  ext_en = 7'h00;
	int          fail_count = 0;
	int          total_checks = 0;
	logic [15:0] rv;

	gpp_top u_gpp_top (.clk(clk), .reset_n(reset_n), .bus_width_select_pin(bw), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .drive_strength_select(drv),
		.shared_port_pins_i(p_i), .shared_port_pins_o(p_o), .shared_port_pins_oe(p_oe));
	gpp_ext_dev u_gpp_ext_dev (.clk(clk), .pins_o(p_o), .pins_oe(p_oe), .ext_val(ext_val),
		.ext_en(ext_en), .pins_i(p_i));

	initial begin
		forever #12.5 clk = ~clk;
	end

	// ****************************************
	// bus and check helpers
	// ****************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 rv = rdata;
	endtask

	task automatic hw_reset();
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset_values();
		rd_reg(gpp_pkg::ADDR_LEVEL); chk(rv, 16'h0000);
		rd_reg(gpp_pkg::ADDR_DRIVE); chk(rv, 16'h0000);
		rd_reg(8'h40); chk(rv, 16'h0000);
		$display("test reset_values done");
	endtask

	task automatic t_outputs();
		wr_reg(gpp_pkg::ADDR_CTRL, 16'h007F);
		wr_reg(gpp_pkg::ADDR_LEVEL, 16'h0055);
		settle();
		chk({9'h000, p_oe}, 16'h007F);
		chk({9'h000, p_o}, 16'h0055);
		rd_reg(gpp_pkg::ADDR_LEVEL); chk(rv, 16'h0055);
		rd_reg(gpp_pkg::ADDR_CTRL); chk(rv, 16'h007F);
		wr_reg(gpp_pkg::ADDR_LEVEL, 16'h002A);
		rd_reg(gpp_pkg::ADDR_LEVEL); chk(rv, 16'h002A);
		$display("test outputs done");
	endtask

	task automatic t_inputs();
		ext_en  <= 7'h7F;
		ext_val <= 7'h5B;
		wr_reg(gpp_pkg::ADDR_CTRL, 16'h0F00);
		settle();
		chk({9'h000, p_oe}, 16'h0000);
		rd_reg(gpp_pkg::ADDR_LEVEL); chk(rv, 16'h000B);
		ext_val <= 7'h24;
		settle();
		rd_reg(gpp_pkg::ADDR_LEVEL); chk(rv, 16'h0004);
		ext_en <= 7'h3F;
		ext_val <= 7'h01;
		wr_reg(gpp_pkg::ADDR_LEVEL, 16'h0040);
		wr_reg(gpp_pkg::ADDR_CTRL, 16'h4140);
		settle();
		chk({9'h000, p_oe}, 16'h0040);
		chk({15'h0000, p_o[6]}, 16'h0001);
		rd_reg(gpp_pkg::ADDR_CTRL); chk(rv, 16'h4140);
		rd_reg(gpp_pkg::ADDR_LEVEL); chk(rv, 16'h0041);
		$display("test inputs done");
	endtask

	task automatic t_drive();
		wr_reg(gpp_pkg::ADDR_DRIVE, 16'h0001);
		rd_reg(gpp_pkg::ADDR_DRIVE); chk(rv, 16'h0001);
		chk({15'h0000, drv}, 16'h0001);
		wr_reg(gpp_pkg::ADDR_DRIVE, 16'h0000);
		rd_reg(gpp_pkg::ADDR_DRIVE); chk(rv, 16'h0000);
		chk({15'h0000, drv}, 16'h0000);
		$display("test drive done");
	endtask

	task automatic t_bus16();
		ext_en <= 7'h00;
		wr_reg(gpp_pkg::ADDR_CTRL, 16'h007F);
		wr_reg(gpp_pkg::ADDR_LEVEL, 16'h0033);
		bw <= 1'b0;
		settle();
		chk({9'h000, p_oe}, 16'h0000);
		rd_reg(gpp_pkg::ADDR_LEVEL); chk(rv, 16'h0000);
		rd_reg(gpp_pkg::ADDR_CTRL); chk(rv, 16'h0000);
		wr_reg(gpp_pkg::ADDR_LEVEL, 16'h0044);
		wr_reg(gpp_pkg::ADDR_CTRL, 16'h0000);
		bw <= 1'b1;
		settle();
		rd_reg(gpp_pkg::ADDR_LEVEL); chk(rv, 16'h0033);
		chk({9'h000, p_o}, 16'h0033);
		rd_reg(gpp_pkg::ADDR_CTRL); chk(rv, 16'h007F);
		hw_reset();
		rd_reg(gpp_pkg::ADDR_LEVEL); chk(rv, 16'h0000);
		// with all pins as outputs the read shows the stored level itself
		wr_reg(gpp_pkg::ADDR_CTRL, 16'h007F);
		rd_reg(gpp_pkg::ADDR_LEVEL); chk(rv, 16'h0000);
		$display("test bus16 and reset done");
	endtask

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// hang guard at 5000 cycles, well past the hundred or so cycles the tests need
	initial begin
		#(25 * 5000);
		fail_count++;
		wrap_up();
	end

	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset_values();
		t_outputs();
		t_inputs();
		t_drive();
		t_bus16();
		wrap_up();
	end
endmodule // gpp_top_bench
